// file: hdl/ncs_defs.svh
`ifndef NCS_DEFS_SVH
`define NCS_DEFS_SVH
`define NCS_ADDR_W 12
`define NCS_OFS_SYNC_CTRL 12'h0219
`define NCS_OFS_RDIV_HI 12'h0217
`define NCS_OFS_RDIV_LO 12'h0218
`define NCS_SYNC_CTRL_RST 8'h02
`define NCS_RDIV_RST 16'h0000
`define NCS_BIT_ON_SYNC 1
`define NCS_BIT_ON_SYSREF 0
`endif

// file: hdl/ncs_pkg.sv
package ncs_pkg;
  typedef enum logic [1:0] {
    NCS_ARM_IDLE,
    NCS_ARM_PRIMED,
    NCS_ARM_ARMED
  } ncs_arm_type;
  typedef enum logic {
    NCS_SYNC_WAIT_EDGE,
    NCS_SYNC_WAIT_BOUNDARY
  } ncs_sync_type;
endpackage

// file: hdl/ncs_acc_if.sv
`timescale 1ns/1ps
// carries divisor, load strobe and phase between the control and accumulator
interface ncs_acc_if #(parameter int ACC_W = 32, parameter int DIV_W = 16);
  logic [DIV_W-1:0] rdiv;
  logic [ACC_W-1:0] freq;
  logic [ACC_W-1:0] phase_ofs;
  logic phase_init;
  logic [ACC_W-1:0] phase;
  modport ctrl (output rdiv, output freq, output phase_ofs,
    output phase_init, input phase);
  modport acc (input rdiv, input freq, input phase_ofs,
    input phase_init, output phase);
endinterface

// file: hdl/ncs_phase_acc.sv
`timescale 1ns/1ps
// phase accumulator; with a nonzero divisor the fraction is tracked as a
// modulo-rdiv remainder so that frequency steps come out exact
module ncs_phase_acc #(
  parameter int ACC_W = 32,
  parameter int DIV_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [DIV_W-1:0] frac_num_i,
  ncs_acc_if.acc acc
);
  logic [ACC_W-1:0] phase_q;
  logic [DIV_W-1:0] rem_q;
  logic [DIV_W:0] rem_sum;
  logic carry;

  // remainder wraps at rdiv; a wrap adds one lsb to the phase
  always_comb begin
    rem_sum = {1'b0, rem_q} + {1'b0, frac_num_i};
    carry = (acc.rdiv != '0) && (rem_sum >= {1'b0, acc.rdiv});
  end

  // zero divisor leaves a plain accumulator
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= '0;
      rem_q <= '0;
    end else if (acc.phase_init) begin
      phase_q <= acc.phase_ofs;
      rem_q <= '0;
    end else begin
      phase_q <= phase_q + acc.freq + ACC_W'(carry);
      if (acc.rdiv == '0) begin
        rem_q <= '0;
      end else if (carry) begin
        rem_q <= DIV_W'(rem_sum - {1'b0, acc.rdiv});
      end else begin
        rem_q <= rem_sum[DIV_W-1:0];
      end
    end
  end

  assign acc.phase = phase_q;
endmodule // ncs_phase_acc

// file: hdl/ncs_ctrl.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "ncs_defs.svh"
// What this block does
// - 16-bit divisor resets to zero; zero gives a plain 32-bit accumulator.
// - one divisor register serves every oscillator preset.
// - sync-request bit set, reset 1: init phase at boundary after rising sync.
// - sync-request init works in both 8b/10b and 64b/66b modes.
// - in 64b/66b mode sync only triggers phase init, never touches link.
// - writing 0 then 1 to the sysref bit arms; next sysref rise inits.
// - after one sysref init, disarm until another 0-then-1 write.
module ncs_ctrl #(
  parameter int ACC_W = 32,
  parameter int DIV_W = 16,
  parameter int ADDR_W = `NCS_ADDR_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sync_n_i,
  input wire logic frame_boundary_i,
  input wire logic link_is_64b66b_i,
  input wire logic sysref_i,
  input wire logic [ACC_W-1:0] freq_word_i,
  input wire logic [DIV_W-1:0] frac_num_i,
  input wire logic [15:0] phase_word_i,
  output logic link_sync_n_o,
  output logic phase_init_o,
  output logic sysref_armed_o,
  output logic [ACC_W-1:0] phase_o
);
  logic [7:0] ctrl_q;
  logic [DIV_W-1:0] rdiv_q;
  logic sync_prev_q;
  logic sysref_prev_q;
  logic link_sync_n_q;
  logic phase_init_q;
  logic armed_q;
  logic [ACC_W-1:0] phase_q;
  ncs_pkg::ncs_arm_type arm_q;
  ncs_pkg::ncs_sync_type sync_st_q;
  logic sync_rise;
  logic sysref_rise;
  logic sync_fire;
  logic sysref_fire;
  logic wr_ctrl;

  ncs_acc_if #(.ACC_W(ACC_W), .DIV_W(DIV_W)) acc_bus ();

  // address decode shared by the read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_ctrl = reg_wr_i && hit(reg_addr_i, ADDR_W'(`NCS_OFS_SYNC_CTRL));

  // control register keeps all eight bits; upper six steer nothing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `NCS_SYNC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  // one divisor for all presets, two byte halves
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdiv_q <= DIV_W'(`NCS_RDIV_RST);
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, ADDR_W'(`NCS_OFS_RDIV_HI))) begin
        rdiv_q[DIV_W-1:8] <= reg_wdata_i[DIV_W-9:0];
      end
      if (hit(reg_addr_i, ADDR_W'(`NCS_OFS_RDIV_LO))) begin
        rdiv_q[7:0] <= reg_wdata_i;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (hit(reg_addr_i, ADDR_W'(`NCS_OFS_SYNC_CTRL))) begin
        reg_rdata_o <= ctrl_q;
      end else if (hit(reg_addr_i, ADDR_W'(`NCS_OFS_RDIV_HI))) begin
        reg_rdata_o <= rdiv_q[DIV_W-1:8];
      end else if (hit(reg_addr_i, ADDR_W'(`NCS_OFS_RDIV_LO))) begin
        reg_rdata_o <= rdiv_q[7:0];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // edge history for the two trigger inputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_prev_q <= 1'b1;
      sysref_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_n_i;
      sysref_prev_q <= sysref_i;
    end
  end

  assign sync_rise = sync_n_i && !sync_prev_q;
  assign sysref_rise = sysref_i && !sysref_prev_q;

  // wait for sync rise, then fire on the next frame boundary; same path for
  // both encodings
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_st_q <= ncs_pkg::NCS_SYNC_WAIT_EDGE;
    end else begin
      case (sync_st_q)
        ncs_pkg::NCS_SYNC_WAIT_EDGE: begin
          if (ctrl_q[`NCS_BIT_ON_SYNC] && sync_rise) begin
            sync_st_q <= ncs_pkg::NCS_SYNC_WAIT_BOUNDARY;
          end
        end
        ncs_pkg::NCS_SYNC_WAIT_BOUNDARY: begin
          if (!ctrl_q[`NCS_BIT_ON_SYNC] || frame_boundary_i) begin
            sync_st_q <= ncs_pkg::NCS_SYNC_WAIT_EDGE;
          end
        end
        default: sync_st_q <= ncs_pkg::NCS_SYNC_WAIT_EDGE;
      endcase
    end
  end

  assign sync_fire = (sync_st_q == ncs_pkg::NCS_SYNC_WAIT_BOUNDARY) &&
                     ctrl_q[`NCS_BIT_ON_SYNC] && frame_boundary_i;

  // sync reaches the link only in 8b/10b; held released in 64b/66b
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_sync_n_q <= 1'b1;
    end else begin
      link_sync_n_q <= link_is_64b66b_i ? 1'b1 : sync_n_i;
    end
  end

  // arming needs a written 0 then a written 1; one shot per arming
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_q <= ncs_pkg::NCS_ARM_IDLE;
    end else begin
      case (arm_q)
        ncs_pkg::NCS_ARM_IDLE: begin
          if (wr_ctrl && !reg_wdata_i[`NCS_BIT_ON_SYSREF]) begin
            arm_q <= ncs_pkg::NCS_ARM_PRIMED;
          end
        end
        ncs_pkg::NCS_ARM_PRIMED: begin
          if (wr_ctrl && reg_wdata_i[`NCS_BIT_ON_SYSREF]) begin
            arm_q <= ncs_pkg::NCS_ARM_ARMED;
          end
        end
        ncs_pkg::NCS_ARM_ARMED: begin
          // a fresh 0 write re-primes; an edge disarms
          if (wr_ctrl && !reg_wdata_i[`NCS_BIT_ON_SYSREF]) begin
            arm_q <= ncs_pkg::NCS_ARM_PRIMED;
          end else if (sysref_rise) begin
            arm_q <= ncs_pkg::NCS_ARM_IDLE;
          end
        end
        default: arm_q <= ncs_pkg::NCS_ARM_IDLE;
      endcase
    end
  end

  // a re-priming 0 write in the edge cycle wins; arm goes primed, edge not taken
  assign sysref_fire = (arm_q == ncs_pkg::NCS_ARM_ARMED) && sysref_rise &&
                       !(wr_ctrl && !reg_wdata_i[`NCS_BIT_ON_SYSREF]);

  // one-cycle init pulse from either trigger
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_init_q <= 1'b0;
    end else begin
      phase_init_q <= sync_fire || sysref_fire;
    end
  end

  // armed flag mirrored out for status
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= (arm_q == ncs_pkg::NCS_ARM_ARMED) && !sysref_fire;
    end
  end

  // accumulator feed; phase offset left-justified into the word
  assign acc_bus.rdiv = rdiv_q;
  assign acc_bus.freq = freq_word_i;
  assign acc_bus.phase_ofs = {phase_word_i, {(ACC_W-16){1'b0}}};
  assign acc_bus.phase_init = phase_init_q;

  ncs_phase_acc #(.ACC_W(ACC_W), .DIV_W(DIV_W)) u_acc (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .frac_num_i(frac_num_i),
    .acc(acc_bus.acc)
  );

  // registered phase output
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= '0;
    end else begin
      phase_q <= acc_bus.phase;
    end
  end

  assign link_sync_n_o = link_sync_n_q;
  assign phase_init_o = phase_init_q;
  assign sysref_armed_o = armed_q;
  assign phase_o = phase_q;
endmodule // ncs_ctrl

// file: bench/ncs_far_end.sv
`timescale 1ns/1ps
// sysref source, multiframe clock and receiver sync line
module ncs_far_end (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire logic hold_i,
  output logic sysref_o,
  output logic sync_n_o,
  output logic boundary_o
);
  logic [3:0] pulse_q;
  logic [2:0] lmfc_q;
  // boundary every eighth cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lmfc_q <= 3'h0;
    else lmfc_q <= lmfc_q + 3'h1;
  end
  assign boundary_o = (lmfc_q == 3'h0);
  // idle until commanded, then two pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pulse_q <= 4'h0;
    else if (fire_i) pulse_q <= 4'h8;
    else if (pulse_q != 4'h0) pulse_q <= pulse_q - 4'h1;
  end
  assign sysref_o = pulse_q[1];
  // low while the receiver asks for realignment
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) sync_n_o <= 1'b1;
    else sync_n_o <= !hold_i;
  end
endmodule // ncs_far_end

// file: bench/ncs_ctrl_sva.sv
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_ctrl_sva #(
  parameter int ACC_W = 32,
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic sync_n_i,
  input wire logic frame_boundary_i,
  input wire logic link_is_64b66b_i,
  input wire logic sysref_i,
  input wire logic [15:0] phase_word_i,
  input wire logic link_sync_n_o,
  input wire logic phase_init_o,
  input wire logic sysref_armed_o,
  input wire logic [ACC_W-1:0] phase_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // a control write with bit 0 clear re-primes and so beats a sysref edge
  wire logic ctrl_wr = reg_wr_i && reg_addr_i == `NCS_OFS_SYNC_CTRL;
  link_hold_a: assert property (link_is_64b66b_i |=> link_sync_n_o)
    else $error("link sync moved in 64b66b mode");
  link_copy_a: assert property (
    !link_is_64b66b_i |=> link_sync_n_o == $past(sync_n_i))
    else $error("link sync not passed on");
  // the armed flag trails the arm state by a cycle, so a re-priming 0 write
  // one cycle back has already closed the arm while the flag still shows it
  arm_fire_a: assert property (
    sysref_armed_o && $rose(sysref_i) && !ctrl_wr &&
    !$past(ctrl_wr && !reg_wdata_i[0])
    |=> phase_init_o && !sysref_armed_o) else $error("armed edge missed");
  arm_hold_a: assert property (
    sysref_armed_o && !sysref_i && !ctrl_wr &&
    !$past(ctrl_wr && !reg_wdata_i[0]) |=> sysref_armed_o)
    else $error("armed state lost");
  // arming write lands in the arm state, the flag follows one edge later
  arm_cause_a: assert property (
    $rose(sysref_armed_o) |-> $past(ctrl_wr, 2) && $past(reg_wdata_i[0], 2))
    else $error("armed without write");
  init_cause_a: assert property (
    $rose(phase_init_o) |-> $past(frame_boundary_i) || $past(sysref_i))
    else $error("init without trigger");
  init_once_a: assert property (phase_init_o |=> !phase_init_o)
    else $error("init pulse too long");
  phase_load_a: assert property (
    phase_init_o |-> ##2 phase_o == {phase_word_i, 16'h0000})
    else $error("phase not loaded");
  rd_quiet_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  cover property (sysref_armed_o && $rose(sysref_i));
  cover property (link_is_64b66b_i && phase_init_o);
  cover property (!link_is_64b66b_i && phase_init_o);
endmodule // ncs_ctrl_sva

// file: bench/ncs_ctrl_test.sv
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_ctrl_test;
  logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic link_is_64b66b_i = 0, fire = 0, hold = 0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic sync_n_i, frame_boundary_i, sysref_i;
  logic link_sync_n_o, phase_init_o, sysref_armed_o;
  logic [31:0] freq_word_i = 32'h0123_4567, phase_o;
  logic [15:0] frac_num_i = 16'h0001, phase_word_i = 16'ha5c3;
  int n_errors = 0, checked = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  ncs_far_end far (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .hold_i(hold), .sysref_o(sysref_i), .sync_n_o(sync_n_i),
    .boundary_o(frame_boundary_i));
  ncs_ctrl dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .sync_n_i(sync_n_i),
    .frame_boundary_i(frame_boundary_i),
    .link_is_64b66b_i(link_is_64b66b_i),
    .sysref_i(sysref_i),
    .freq_word_i(freq_word_i),
    .frac_num_i(frac_num_i),
    .phase_word_i(phase_word_i),
    .link_sync_n_o(link_sync_n_o),
    .phase_init_o(phase_init_o),
    .sysref_armed_o(sysref_armed_o),
    .phase_o(phase_o)
  );
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rreg(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // counts init pulses seen over a fixed span
  task count_init(output int n);
    n = 0;
    repeat (20) begin
      @(posedge ref_clk_i);
      #1 if (phase_init_o === 1'b1) n++;
    end
  endtask
  task t_regs;
    rreg(`NCS_OFS_SYNC_CTRL, 8'h02);
    rreg(`NCS_OFS_RDIV_HI, 8'h00);
    rreg(`NCS_OFS_RDIV_LO, 8'h00);
    rreg(12'h0ff, 8'h00);
    wreg(`NCS_OFS_SYNC_CTRL, 8'hfe);
    rreg(`NCS_OFS_SYNC_CTRL, 8'hfe);
    wreg(`NCS_OFS_SYNC_CTRL, 8'h02);
  endtask
  task t_acc;
    logic [31:0] p;
    @(posedge ref_clk_i);
    #1 p = phase_o;
    @(posedge ref_clk_i);
    #1 chk(phase_o - p, freq_word_i);
    // whole-number divisor, well below the spur limit, word kept as is
    wreg(`NCS_OFS_RDIV_LO, 8'h04);
    repeat (3) @(posedge ref_clk_i);
    #1 p = phase_o;
    repeat (4) @(posedge ref_clk_i);
    #1 chk(phase_o - p, freq_word_i * 4 + 1);
    wreg(`NCS_OFS_RDIV_LO, 8'h00);
  endtask
  task t_sync;
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk_i);
      link_is_64b66b_i <= m[0];
      // new frequency word, so the phase must be re-synchronised
      freq_word_i <= 32'h0765_4321;
      hold <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1 chk(link_sync_n_o, m);
      @(posedge ref_clk_i);
      hold <= 1'b0;
      for (int i = 0; i < 40 && phase_init_o !== 1'b1; i++) begin
        @(posedge ref_clk_i);
        #1;
      end
      chk(phase_init_o, 1);
      repeat (2) @(posedge ref_clk_i);
      #1 chk(phase_o, {phase_word_i, 16'h0000});
    end
  endtask
  task t_sysref;
    int n;
    // clock running and out of reset before arming; sysref still idle
    wreg(`NCS_OFS_SYNC_CTRL, 8'h00);
    wreg(`NCS_OFS_SYNC_CTRL, 8'h01);
    // status flag follows the arm state one edge later
    @(posedge ref_clk_i);
    #1 chk(sysref_armed_o, 1);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      fire <= 1'b1;
      @(posedge ref_clk_i);
      fire <= 1'b0;
      count_init(n);
      chk(n, 1 - k);
      chk(sysref_armed_o, 0);
      wreg(`NCS_OFS_SYNC_CTRL, 8'h01);
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_acc;
    t_sync;
    t_sysref;
    conclude;
  end
  initial begin
    #40000;
    n_errors++;
    conclude;
  end
endmodule // ncs_ctrl_test
bind ncs_ctrl ncs_ctrl_sva #(.ACC_W(ACC_W), .ADDR_W(ADDR_W)) sva_i (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .sync_n_i(sync_n_i),
  .frame_boundary_i(frame_boundary_i),
  .link_is_64b66b_i(link_is_64b66b_i),
  .sysref_i(sysref_i),
  .phase_word_i(phase_word_i),
  .link_sync_n_o(link_sync_n_o),
  .phase_init_o(phase_init_o),
  .sysref_armed_o(sysref_armed_o),
  .phase_o(phase_o)
);
